// File: rtl/bkc_breakpoint.sv
// comparator C match, breakpoint control register and break request logic
//
// Our own choices: strobed register access and the placing of the registers.
`timescale 1ns/1ps

// Overview of operation
// R1 - each compare bit demands a zero or a one on its address bit
// R2 - compare value clears itself when armed with single-loop capture
// R3 - page bit low: no extended compare, high byte against address 15:8
// R4 - page bit high: extended 21:16 compared, high byte uses 15:14 and 13:8
// R5 - A/B enable starts A/B breakpoints and blocks debug-mode enable
// R6 - with A/B enable set every control-two bit is functional
// R7 - A/B off in debug mode: full and A/B tag have no effect
// R8 - full select: 0 dual address, 1 address on A and data on B
// R9 - break action bit: 0 software interrupt, 1 background mode
// R10 - A/B tag: 0 forced at boundary, 1 tagged on execution only
// R11 - C enable turns on C breaks, cleared when armed in single-loop
// R12 - C tag: 0 forced at boundary, 1 tagged on execution only
// R13 - direction qualify enable includes bus direction in C match
// R14 - direction value: 0 writes match, 1 reads match; unused if off
// R15 - C bits work in both modes except under single-loop capture
// R16 - upper page-select bit is ignored
// R17 - software keeps the two top extended-compare bits at zero
// R18 - control two resets to zero with every breakpoint disabled
module bkc_breakpoint
	import bkc_pkg::*;
(
	input  wire logic        core_clk,
	input  wire logic        rst,
	input  wire logic        ce,
	input  wire logic [3:0]  reg_addr,
	input  wire logic [7:0]  reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [7:0]  reg_rdata,
	input  wire bkc_bus_t    cpu_bus,
	input  wire logic        instr_boundary,
	input  wire logic        tag_exec,
	input  wire logic        ab_hit,
	output bkc_brk_t         brk_req,
	output logic             c_tag_req,
	output logic             ab_tag_req,
	output logic             ab_full_mode,
	output logic             ab_active,
	output logic             irq
);

	//------------------------------------------------------------
	// register state
	//------------------------------------------------------------
	logic [7:0]  ctrl2_q;
	logic [7:0]  ctrl1_q;
	logic [15:0] cc_q;
	logic [7:0]  ccx_q;
	logic [1:0]  status_q;
	logic [1:0]  mask_q;
	logic [7:0]  rdata_q;
	logic        force_pend_q;
	logic        irq_q;
	bkc_brk_t    brk_q;
	logic        c_tag_q;
	logic        ab_tag_q;
	logic        full_q;
	logic        ab_act_q;

	logic        wr_ctrl2;
	logic        wr_ctrl1;
	logic        arm_single_loop_capture;
	logic        c_live;
	logic        c_hit;
	logic        ab_live;
	logic        forced_hit;
	logic        fire;

	// decode of a register write at one offset
	function automatic logic wr_at(input logic [3:0] ofs);
		return reg_wr && (reg_addr == ofs);
	endfunction

	// comparator C address test; the upper page bit never reaches it
	function automatic logic c_addr_eq(input bkc_bus_t b,
			input logic [15:0] cv, input logic [7:0] cx);
		logic       paged;
		logic [7:0] hi;
		logic       ext_ok;
		paged  = cx[BKC_CCX_PSEL_LO]; // R16
		hi     = paged ? {b.ext_addr[1:0], b.addr[13:8]} : b.addr[15:8]; // R3 R4
		ext_ok = !paged || (cx[5:0] == b.ext_addr[7:2]); // R4
		return ext_ok && (hi == cv[15:8]) && (b.addr[7:0] == cv[7:0]); // R1
	endfunction

	assign wr_ctrl2  = wr_at(BKC_OFS_CTRL2);
	assign wr_ctrl1  = wr_at(BKC_OFS_CTRL1);
	// arming with the single-loop selection in the same write
	assign arm_single_loop_capture = wr_ctrl1 && reg_wdata[BKC_C1_ARM] && reg_wdata[BKC_C1_SINGLE_LOOP_CAPTURE];

	//------------------------------------------------------------
	// breakpoint_control_two
	//------------------------------------------------------------
	// arming in single-loop beats a simultaneous write of the enable
	always_ff @(posedge core_clk) begin
		if (rst) begin
			ctrl2_q <= BKC_RST_CTRL2; // R18
		end else if (ce) begin
			if (wr_ctrl2) begin
				ctrl2_q <= reg_wdata; // R6
			end
			if (arm_single_loop_capture) begin
				ctrl2_q[BKC_C2_C_EN] <= 1'b0; // R11
			end
		end
	end

	//------------------------------------------------------------
	// debug_control_one (arm, debug-mode enable, single loop)
	//------------------------------------------------------------
	// debug-mode enable cannot be written high while A/B breakpoints own the unit
	always_ff @(posedge core_clk) begin
		if (rst) begin
			ctrl1_q <= BKC_RST_CTRL1;
		end else if (ce && wr_ctrl1) begin
			ctrl1_q <= reg_wdata;
			if (ctrl2_q[BKC_C2_AB_EN]) begin
				ctrl1_q[BKC_C1_DBG_EN] <= 1'b0; // R5
			end
		end
	end

	//------------------------------------------------------------
	// comparator C value and extended register
	//------------------------------------------------------------
	// each byte is writable alone; arming in single-loop wipes both
	always_ff @(posedge core_clk) begin
		if (rst) begin
			cc_q <= BKC_RST_CC;
		end else if (ce) begin
			if (wr_at(BKC_OFS_CC_HI)) begin
				cc_q[15:8] <= reg_wdata;
			end
			if (wr_at(BKC_OFS_CC_LO)) begin
				cc_q[7:0] <= reg_wdata;
			end
			if (arm_single_loop_capture) begin
				cc_q <= BKC_RST_CC; // R2
			end
		end
	end

	// stored as written; top extended bits are software's duty
	always_ff @(posedge core_clk) begin
		if (rst) begin
			ccx_q <= BKC_RST_CCX;
		end else if (ce && wr_at(BKC_OFS_CCX)) begin
			ccx_q <= reg_wdata; // R17
		end
	end

	//------------------------------------------------------------
	// match qualification
	//------------------------------------------------------------
	// C is dead under single-loop capture in debug mode
	assign c_live = ctrl2_q[BKC_C2_C_EN] &&
		!(ctrl1_q[BKC_C1_DBG_EN] && ctrl1_q[BKC_C1_SINGLE_LOOP_CAPTURE]); // R15 R11
	assign c_hit = c_live && cpu_bus.valid && c_addr_eq(cpu_bus, cc_q, ccx_q) &&
		(!ctrl2_q[BKC_C2_C_DQEN] ||
		(cpu_bus.rd == ctrl2_q[BKC_C2_C_DIR])); // R13 R14
	assign ab_live = ctrl2_q[BKC_C2_AB_EN] && ab_hit; // R5

	// forced hits wait for a boundary; tagged ones go to the core
	assign forced_hit = (c_hit && !ctrl2_q[BKC_C2_C_TAG]) ||
		(ab_live && !ctrl2_q[BKC_C2_AB_TAG]); // R10 R12
	assign fire = force_pend_q ? instr_boundary : 1'b0;

	//------------------------------------------------------------
	// mode outputs toward the A/B datapath
	//------------------------------------------------------------
	// full and A/B tag carry no meaning without the A/B enable
	always_ff @(posedge core_clk) begin
		if (rst) begin
			full_q   <= 1'b0;
			ab_act_q <= 1'b0;
		end else if (ce) begin
			full_q   <= ctrl2_q[BKC_C2_AB_EN] && ctrl2_q[BKC_C2_FULL]; // R7 R8
			ab_act_q <= ctrl2_q[BKC_C2_AB_EN]; // R5
		end
	end

	//------------------------------------------------------------
	// tag requests
	//------------------------------------------------------------
	// the core marks the fetched opcode; it answers with tag_exec only
	// when that opcode really executes, so flushed ones never break
	always_ff @(posedge core_clk) begin
		if (rst) begin
			c_tag_q  <= 1'b0;
			ab_tag_q <= 1'b0;
		end else if (ce) begin
			c_tag_q  <= c_hit && ctrl2_q[BKC_C2_C_TAG]; // R12
			ab_tag_q <= ab_live && ctrl2_q[BKC_C2_AB_TAG]; // R10 R7
		end
	end

	//------------------------------------------------------------
	// forced break pending
	//------------------------------------------------------------
	// a new hit in the boundary cycle keeps the request alive
	always_ff @(posedge core_clk) begin
		if (rst) begin
			force_pend_q <= 1'b0;
		end else if (ce) begin
			if (forced_hit) begin
				force_pend_q <= 1'b1; // R10 R12
			end else if (instr_boundary) begin
				force_pend_q <= 1'b0;
			end
		end
	end

	//------------------------------------------------------------
	// break request to the core
	//------------------------------------------------------------
	// one-cycle pulse on the path chosen by the break-action bit
	always_ff @(posedge core_clk) begin
		if (rst) begin
			brk_q <= '0;
		end else if (ce) begin
			brk_q.to_bgnd <= (fire || tag_exec) && ctrl2_q[BKC_C2_BGND]; // R9
			brk_q.to_swi  <= (fire || tag_exec) && !ctrl2_q[BKC_C2_BGND]; // R9
		end
	end

	//------------------------------------------------------------
	// interrupt status, mask and output
	//------------------------------------------------------------
	// write-one-to-clear; a new event in the same cycle wins
	always_ff @(posedge core_clk) begin
		if (rst) begin
			status_q <= BKC_RST_IRQ;
		end else if (ce) begin
			if (wr_at(BKC_OFS_STATUS)) begin
				status_q <= status_q & ~reg_wdata[1:0];
			end
			if (c_hit) begin
				status_q[BKC_ST_CHIT] <= 1'b1;
			end
			if (fire || tag_exec) begin
				status_q[BKC_ST_BREAK] <= 1'b1;
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			mask_q <= BKC_RST_IRQ;
		end else if (ce && wr_at(BKC_OFS_MASK)) begin
			mask_q <= reg_wdata[1:0];
		end
	end

	// level output, one cycle behind the status flops
	always_ff @(posedge core_clk) begin
		if (rst) begin
			irq_q <= 1'b0;
		end else if (ce) begin
			irq_q <= |(status_q & mask_q);
		end
	end

	//------------------------------------------------------------
	// register read port
	//------------------------------------------------------------
	// data stand one cycle after the strobe, zero otherwise
	always_ff @(posedge core_clk) begin
		if (rst) begin
			rdata_q <= 8'h00;
		end else if (ce) begin
			rdata_q <= 8'h00;
			if (reg_rd) begin
				case (reg_addr)
					BKC_OFS_CTRL2:  rdata_q <= ctrl2_q;
					BKC_OFS_CC_HI:  rdata_q <= cc_q[15:8];
					BKC_OFS_CC_LO:  rdata_q <= cc_q[7:0];
					BKC_OFS_CCX:    rdata_q <= ccx_q;
					BKC_OFS_CTRL1:  rdata_q <= ctrl1_q;
					BKC_OFS_STATUS: rdata_q <= {6'h00, status_q};
					BKC_OFS_MASK:   rdata_q <= {6'h00, mask_q};
					default:        rdata_q <= 8'h00; // unmapped reads zero
				endcase
			end
		end
	end

	assign reg_rdata    = rdata_q;
	assign brk_req      = brk_q;
	assign c_tag_req    = c_tag_q;
	assign ab_tag_req   = ab_tag_q;
	assign ab_full_mode = full_q;
	assign ab_active    = ab_act_q;
	assign irq          = irq_q;

	//------------------------------------------------------------
	// assertions
	//------------------------------------------------------------
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);

	sequence s_arm_single_loop_capture;
		ce && arm_single_loop_capture;
	endsequence

	sequence s_forced_c;
		ce && c_hit && !ctrl2_q[BKC_C2_C_TAG] && !instr_boundary;
	endsequence

	a_arm_clears_cc: assert property (s_arm_single_loop_capture |=> cc_q == BKC_RST_CC) // R2
		else $error("compare value not cleared on single-loop arm");

	a_arm_clears_cen: assert property (s_arm_single_loop_capture |=> !ctrl2_q[BKC_C2_C_EN]) // R11
		else $error("c enable not cleared on single-loop arm");

	a_debug_mode_enable_blocked: assert property (ctrl2_q[BKC_C2_AB_EN] && ce && wr_ctrl1
		|=> !ctrl1_q[BKC_C1_DBG_EN]) // R5
		else $error("debug-mode enable set while a/b enabled");

	a_full_gated: assert property (ce && !ctrl2_q[BKC_C2_AB_EN] |=> !ab_full_mode) // R7
		else $error("full mode shown without a/b enable");

	a_c_unpaged: assert property (ce && c_live && cpu_bus.valid &&
		!ctrl2_q[BKC_C2_C_DQEN] && !ccx_q[BKC_CCX_PSEL_LO] &&
		cpu_bus.addr == cc_q |-> c_hit) // R1 R3 R16
		else $error("unpaged address equal to compare value missed");

	a_c_dir: assert property (c_hit && ctrl2_q[BKC_C2_C_DQEN]
		|-> cpu_bus.rd == ctrl2_q[BKC_C2_C_DIR]) // R13 R14
		else $error("c match ignores qualified direction");

	a_c_paged_ext: assert property (c_hit && ccx_q[BKC_CCX_PSEL_LO]
		|-> ccx_q[5:0] == cpu_bus.ext_addr[7:2]) // R4
		else $error("paged c match with wrong extended bits");

	a_single_loop_capture_blocks_c: assert property (ctrl1_q[BKC_C1_DBG_EN] &&
		ctrl1_q[BKC_C1_SINGLE_LOOP_CAPTURE] |-> !c_hit) // R15
		else $error("c match under single-loop capture");

	a_forced_break: assert property (s_forced_c ##1 (ce && instr_boundary)
		|=> brk_req.to_swi != brk_req.to_bgnd) // R12 R9
		else $error("forced c break not raised at boundary");

	a_break_path: assert property (ce && tag_exec
		|=> brk_req.to_bgnd == $past(ctrl2_q[BKC_C2_BGND]) &&
		brk_req.to_swi == !$past(ctrl2_q[BKC_C2_BGND])) // R9 R10
		else $error("break routed to wrong action");

	a_ctrl2_reset: assert property ($past(rst) |-> ctrl2_q == BKC_RST_CTRL2) // R18
		else $error("control two not zero after reset");

	a_tag_no_force: assert property (ce && c_hit && ctrl2_q[BKC_C2_C_TAG] &&
		!ab_live |=> !force_pend_q || $past(force_pend_q)) // R12
		else $error("tagged c match made a forced break");

	a_brk_onehot: assert property (!(brk_req.to_bgnd && brk_req.to_swi)) // R9
		else $error("break raised on both action paths");

	a_ab_active: assert property (ce |=> ab_active == $past(ctrl2_q[BKC_C2_AB_EN])) // R5
		else $error("a/b active does not follow its enable");

	a_ab_tag_gated: assert property (ce && !ctrl2_q[BKC_C2_AB_EN] |=> !ab_tag_req) // R7
		else $error("a/b tag request without a/b enable");

	a_c_tag_req: assert property (ce && c_hit && ctrl2_q[BKC_C2_C_TAG] |=> c_tag_req) // R12
		else $error("tagged c match did not tag the fetch");

	a_c_off_quiet: assert property (!ctrl2_q[BKC_C2_C_EN] |-> !c_hit) // R11
		else $error("c match while c enable is clear");

	// a low clock enable must hold the control and compare registers
	a_ce_freeze: assert property (!ce |=> $stable(ctrl2_q) && $stable(cc_q)) // R6
		else $error("state moved while clock enable low");

endmodule

// File: rtl/bkc_pkg.sv
// shared constants and types of the comparator C breakpoint control block
package bkc_pkg;

	// register map, byte offsets on the 4-bit register port
	localparam logic [3:0] BKC_OFS_CTRL2  = 4'h0;
	localparam logic [3:0] BKC_OFS_CC_HI  = 4'h1;
	localparam logic [3:0] BKC_OFS_CC_LO  = 4'h2;
	localparam logic [3:0] BKC_OFS_CCX    = 4'h3;
	localparam logic [3:0] BKC_OFS_CTRL1  = 4'h4;
	localparam logic [3:0] BKC_OFS_STATUS = 4'h5;
	localparam logic [3:0] BKC_OFS_MASK   = 4'h6;

	// breakpoint_control_two field positions
	localparam int BKC_C2_AB_EN   = 7;
	localparam int BKC_C2_FULL    = 6;
	localparam int BKC_C2_BGND    = 5;
	localparam int BKC_C2_AB_TAG  = 4;
	localparam int BKC_C2_C_EN    = 3;
	localparam int BKC_C2_C_TAG   = 2;
	localparam int BKC_C2_C_DQEN  = 1;
	localparam int BKC_C2_C_DIR   = 0;

	// debug_control_one field positions
	localparam int BKC_C1_ARM     = 7;
	localparam int BKC_C1_DBG_EN  = 6;
	localparam int BKC_C1_SINGLE_LOOP_CAPTURE   = 0;

	// extended register fields
	localparam int BKC_CCX_PSEL_LO = 6;

	// status / mask bit positions
	localparam int BKC_ST_CHIT  = 0;
	localparam int BKC_ST_BREAK = 1;

	// reset values
	localparam logic [7:0]  BKC_RST_CTRL2 = 8'h00;
	localparam logic [7:0]  BKC_RST_CTRL1 = 8'h00;
	localparam logic [15:0] BKC_RST_CC    = 16'h0000;
	localparam logic [7:0]  BKC_RST_CCX   = 8'h00;
	localparam logic [1:0]  BKC_RST_IRQ   = 2'h0;

	// one sample of the cpu address bus
	typedef struct packed {
		logic        valid;    // a bus cycle is in progress
		logic        rd;       // 1 read, 0 write
		logic [7:0]  ext_addr; // extended address bus bits 21:14
		logic [15:0] addr;     // cpu address bus bits 15:0
	} bkc_bus_t;

	// break request toward the core
	typedef struct packed {
		logic to_bgnd; // enter background mode
		logic to_swi;  // start a software interrupt
	} bkc_brk_t;

endpackage

// File: verification/bkc_core_model.sv
// behavioural cpu core that drives bus cycles, boundaries and tag strobes
`timescale 1ns/1ps

module bkc_core_model
	import bkc_pkg::*;
(
	input  wire logic core_clk,
	output bkc_bus_t  cpu_bus,
	output logic      instr_boundary,
	output logic      tag_exec,
	output logic      ab_hit
);
	// idle until the bench asks for a cycle
	initial begin
		cpu_bus = '0;
		instr_boundary = 1'b0;
		tag_exec = 1'b0;
		ab_hit = 1'b0;
	end

	// one bus cycle, a slow core waits gap cycles before the boundary;
	// the released bus shows inverted values so stale matches cannot hide
	task automatic cycle(input logic [15:0] ad, input logic [7:0] ex, input logic rd,
			input logic ab, input logic tex, input int gap);
		@(posedge core_clk);
		cpu_bus <= '{1'b1, rd, ex, ad};
		ab_hit <= ab;
		@(posedge core_clk);
		cpu_bus <= '{1'b0, ~rd, ~ex, ~ad};
		ab_hit <= 1'b0;
		repeat (gap) @(posedge core_clk);
		instr_boundary <= 1'b1;
		tag_exec <= tex;
		@(posedge core_clk);
		instr_boundary <= 1'b0;
		tag_exec <= 1'b0;
	endtask
endmodule

// File: verification/test_bkc_breakpoint.sv
// self-checking bench of the comparator C breakpoint control block
`timescale 1ns/1ps

module test_bkc_breakpoint;
	import bkc_pkg::*;
	logic        core_clk = 1'b0;
	logic        rst = 1'b1;
	logic        ce = 1'b1;
	logic [3:0]  reg_addr = 4'h0;
	logic [7:0]  reg_wdata = 8'h00;
	logic        reg_wr = 1'b0;
	logic        reg_rd = 1'b0;
	logic        rd_d1 = 1'b0;
	logic [7:0]  reg_rdata;
	bkc_bus_t    cpu_bus;
	logic        instr_boundary;
	logic        tag_exec;
	logic        ab_hit;
	bkc_brk_t    brk_req;
	logic        c_tag_req;
	logic        ab_tag_req;
	logic        ab_full_mode;
	logic        ab_active;
	logic        irq;
	int          fail_count = 0;
	int          checks_done = 0;
	logic [7:0]  rd_q[$];
	logic [1:0]  brk_q[$];
	logic [1:0]  tag_q[$];
	logic [15:0] a = 16'h0042;

	initial begin
		forever #4 core_clk = ~core_clk;
	end

	bkc_breakpoint u_dut (.core_clk(core_clk), .rst(rst), .ce(ce), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.cpu_bus(cpu_bus), .instr_boundary(instr_boundary), .tag_exec(tag_exec),
		.ab_hit(ab_hit), .brk_req(brk_req), .c_tag_req(c_tag_req), .ab_tag_req(ab_tag_req),
		.ab_full_mode(ab_full_mode), .ab_active(ab_active), .irq(irq));
	bkc_core_model u_core (.core_clk(core_clk), .cpu_bus(cpu_bus),
		.instr_boundary(instr_boundary), .tag_exec(tag_exec), .ab_hit(ab_hit));

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		checks_done++;
		if (seen !== exp) begin
			fail_count++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [3:0] ad, input logic [7:0] d);
		@(posedge core_clk);
		reg_addr <= ad;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] ad, input logic [7:0] exp);
		@(posedge core_clk);
		rd_q.push_back(exp);
		reg_addr <= ad;
		reg_rd <= 1'b1;
		@(posedge core_clk);
		reg_rd <= 1'b0;
	endtask
	// registered levels need the write edge plus one cycle to show
	task automatic see(ref logic v, input logic e);
		repeat (2) @(negedge core_clk);
		check({7'h00, v}, {7'h00, e});
	endtask
	task automatic final_report();
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	// ----------------------------------------
	// result watcher: an unexpected break meets an empty queue and fails
	// ----------------------------------------
	always @(posedge core_clk) begin
		rd_d1 <= reg_rd;
	end
	always @(negedge core_clk) begin
		if (rd_d1) begin
			check(reg_rdata, rd_q.size() ? rd_q.pop_front() : 8'hXX);
		end
		if (brk_req !== 2'b00) begin
			check({6'h00, brk_req}, brk_q.size() ? {6'h00, brk_q.pop_front()} : 8'hXX);
		end
		// tag requests noted as {c, a/b}
		if ({c_tag_req, ab_tag_req} !== 2'b00) begin
			check({6'h00, c_tag_req, ab_tag_req},
				tag_q.size() ? {6'h00, tag_q.pop_front()} : 8'hXX);
		end
	end

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	initial begin
		repeat (10) @(posedge core_clk);
		rst <= 1'b0;
		rd(BKC_OFS_CTRL2, BKC_RST_CTRL2);
		rd(4'hF, 8'h00);
		// a write while the clock enable is low must not land
		ce <= 1'b0;
		wr(BKC_OFS_CTRL2, 8'hFF);
		ce <= 1'b1;
		rd(BKC_OFS_CTRL2, BKC_RST_CTRL2);
		a = lfsr(a);
		wr(BKC_OFS_CTRL2, a[7:0]);
		rd(BKC_OFS_CTRL2, a[7:0]);
		wr(BKC_OFS_CTRL2, 8'h40);
		see(ab_full_mode, 1'b0);
		see(ab_active, 1'b0);
		wr(BKC_OFS_CTRL2, 8'hC0);
		wr(BKC_OFS_CTRL1, 8'h40);
		rd(BKC_OFS_CTRL1, 8'h00);
		see(ab_full_mode, 1'b1);
		see(ab_active, 1'b1);
		brk_q.push_back(2'b01);
		u_core.cycle(a, 8'h00, 1'b0, 1'b1, 1'b0, 0);
		// tagged a/b match asks the core to tag, no forced break
		wr(BKC_OFS_CTRL2, 8'h90);
		tag_q.push_back(2'b01);
		u_core.cycle(a, 8'h00, 1'b0, 1'b1, 1'b0, 0);
		// without the a/b enable its tag select has no effect
		wr(BKC_OFS_CTRL2, 8'h10);
		u_core.cycle(a, 8'h00, 1'b0, 1'b1, 1'b0, 0);
		// forced C breaks, both actions, prompt and slow core
		for (int i = 0; i < 4; i++) begin
			a = lfsr(a);
			wr(BKC_OFS_CC_HI, a[15:8]);
			wr(BKC_OFS_CC_LO, a[7:0]);
			wr(BKC_OFS_CCX, 8'h00);
			wr(BKC_OFS_CTRL2, {2'b00, i[0], 5'b01000});
			u_core.cycle(a ^ (16'h0001 << (i * 4)), 8'h00, 1'b0, 1'b0, 1'b0, 0);
			brk_q.push_back({i[0], ~i[0]});
			u_core.cycle(a, a[7:0], 1'b0, 1'b0, 1'b0, i * 2);
		end
		// direction qualification over both bus directions
		for (int j = 0; j < 4; j++) begin
			wr(BKC_OFS_CTRL2, {7'b0000101, j[0]});
			if (j[0] == j[1]) brk_q.push_back(2'b01);
			u_core.cycle(a, 8'h00, j[1], 1'b0, 1'b0, 0);
		end
		// page compare, upper page bit ignored, top extended bits kept zero
		wr(BKC_OFS_CTRL2, 8'h08);
		for (int k = 0; k < 4; k++) begin
			wr(BKC_OFS_CCX, {k[0], 1'b1, 6'h0B});
			if (!k[1]) brk_q.push_back(2'b01);
			u_core.cycle({~a[15:14], a[13:0]}, {6'h0B ^ {5'h00, k[1]}, a[15:14]},
				1'b0, 1'b0, 1'b0, 0);
		end
		wr(BKC_OFS_CCX, 8'h8B);
		brk_q.push_back(2'b01);
		u_core.cycle(a, 8'hFF, 1'b0, 1'b0, 1'b0, 0);
		// tagged: only an executed opcode breaks
		wr(BKC_OFS_CCX, 8'h00);
		wr(BKC_OFS_CTRL2, 8'h0C);
		tag_q.push_back(2'b10);
		u_core.cycle(a, 8'h00, 1'b0, 1'b0, 1'b0, 0);
		tag_q.push_back(2'b10);
		brk_q.push_back(2'b01);
		u_core.cycle(a, 8'h00, 1'b0, 1'b0, 1'b1, 0);
		// interrupt raised, masked and cleared
		wr(BKC_OFS_STATUS, 8'hFF);
		wr(BKC_OFS_MASK, 8'h02);
		wr(BKC_OFS_CTRL2, 8'h08);
		see(irq, 1'b0);
		brk_q.push_back(2'b01);
		u_core.cycle(a, 8'h00, 1'b0, 1'b0, 1'b0, 0);
		see(irq, 1'b1);
		wr(BKC_OFS_MASK, 8'h00);
		see(irq, 1'b0);
		wr(BKC_OFS_MASK, 8'h02);
		see(irq, 1'b1);
		wr(BKC_OFS_STATUS, 8'h02);
		see(irq, 1'b0);
		// single-loop capture in debug mode silences C, plain debug mode keeps it
		wr(BKC_OFS_CTRL1, 8'h41);
		u_core.cycle(a, 8'h00, 1'b0, 1'b0, 1'b0, 0);
		wr(BKC_OFS_CTRL1, 8'h40);
		brk_q.push_back(2'b01);
		u_core.cycle(a, 8'h00, 1'b0, 1'b0, 1'b0, 0);
		// arming in single-loop mode wipes the match value and C enable
		wr(BKC_OFS_CTRL1, 8'h81);
		rd(BKC_OFS_CC_HI, 8'h00);
		rd(BKC_OFS_CC_LO, 8'h00);
		rd(BKC_OFS_CTRL2, 8'h00);
		// a second reset in mid-run puts control two back to zero
		wr(BKC_OFS_CTRL2, 8'hFF);
		wr(BKC_OFS_MASK, 8'h03);
		@(posedge core_clk);
		rst <= 1'b1;
		repeat (2) @(posedge core_clk);
		rst <= 1'b0;
		rd(BKC_OFS_CTRL2, BKC_RST_CTRL2);
		rd(BKC_OFS_MASK, 8'h00);
		repeat (4) @(negedge core_clk);
		check(8'(rd_q.size() + brk_q.size() + tag_q.size()), 8'h00);
		final_report();
	end

	// watchdog well past the expected few hundred cycles
	initial begin
		#(30000 * 8);
		fail_count++;
		final_report();
	end
endmodule
